/* File: core/dual_timer_top.sv */
// Two 8+8 bit timer/counters with shared mode register
module dual_timer_top
	import tmr_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Register byte port
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	// Control register bit port
	input wire logic SFR_BIT_WR,
	input wire logic [7:0] SFR_BIT_ADDR,
	input wire logic SFR_BIT_VAL,
	// Interrupt vector acknowledges
	input wire logic VEC_ACK_ZERO,
	input wire logic VEC_ACK_ONE,
	// External pins
	input wire logic COUNT_PIN_ZERO,
	input wire logic COUNT_PIN_ONE,
	input wire logic GATE_PIN_ZERO,
	input wire logic GATE_PIN_ONE,
	// Overflow flags
	output logic OVERFLOW_FLAG_ZERO,
	output logic OVERFLOW_FLAG_ONE
);
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [7:0] mode_ff;
	logic [1:0] run_ff;
	logic [1:0] flag_ff;
	logic [3:0] ext_ctl_ff;
	logic [7:0] low_ff [2];
	logic [7:0] high_ff [2];
	logic [7:0] rdata_ff;
	logic [7:0] nxt_low [2];
	logic [7:0] nxt_high [2];
	logic [1:0] ovf_set;
	logic [1:0] gate_pin;
	logic [1:0] gate_sel;
	logic [1:0] csel;
	logic [1:0] enable;
	logic [1:0] step_ok;
	logic [1:0] cnt_wr;
	logic split0;
	logic bit_hit;
	logic [2:0] bit_idx;
	timer_mode_t md [2];

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// Machine cycle sequencer
	timer_step_if step_bus ();
	machine_phase u_phase (
		.clk(CLOCK),
		.rst_n(rst_n),
		.count_pins({COUNT_PIN_ONE, COUNT_PIN_ZERO}),
		.step(step_bus.src)
	);

	////////////////////////////////////////////////////////////////////////
	// Per timer decode of mode and enables
	assign gate_pin = {GATE_PIN_ONE, GATE_PIN_ZERO};
	assign split0 = (md[0] == MODE_SPLIT);
	for (genvar i = 0; i < 2; i++) begin : g_dec
		assign gate_sel[i] = mode_ff[MODE_GATE_BIT0 + MODE_NIBBLE * i];
		assign csel[i] = mode_ff[MODE_CSEL_BIT0 + MODE_NIBBLE * i];
		assign md[i] = timer_mode_t'(mode_ff[MODE_FIELD_LSB0 + MODE_NIBBLE * i +: 2]);
		// run bit enable
		// Timer 1 loses its run bit to the split high byte of timer 0
		assign enable[i] = ((i == 1 && split0) || run_ff[i]) && (!gate_sel[i] || gate_pin[i]);
		assign step_ok[i] = enable[i] && (csel[i] ? step_bus.edge_evt[i] : step_bus.tick);
		assign cnt_wr[i] = SFR_WR && (SFR_ADDR == (i == 0 ? ADDR_LOW0 : ADDR_LOW1) ||
			SFR_ADDR == (i == 0 ? ADDR_HIGH0 : ADDR_HIGH1));
	end

	////////////////////////////////////////////////////////////////////////
	// Next count values, software write wins over counting
	always_comb begin
		ovf_set = 2'b00;
		for (int i = 0; i < 2; i++) begin
			nxt_low[i] = low_ff[i];
			nxt_high[i] = high_ff[i];
			if (step_ok[i]) begin
				case (md[i])
					MODE_PRESCALE13: begin
						nxt_low[i] = low_ff[i] + 8'h01;
						if (low_ff[i][4:0] == PRESCALE_FULL) begin
							nxt_high[i] = high_ff[i] + 8'h01;
							ovf_set[i] = (high_ff[i] == BYTE_FULL);
						end
					end
					MODE_CASCADE16: begin
						nxt_low[i] = low_ff[i] + 8'h01;
						if (low_ff[i] == BYTE_FULL) begin
							nxt_high[i] = high_ff[i] + 8'h01;
							ovf_set[i] = (high_ff[i] == BYTE_FULL);
						end
					end
					MODE_RELOAD8: begin
						if (low_ff[i] == BYTE_FULL) begin
							nxt_low[i] = high_ff[i];
							ovf_set[i] = 1'b1;
						end else begin
							nxt_low[i] = low_ff[i] + 8'h01;
						end
					end
					default: begin
						if (i == 0) begin
							nxt_low[i] = low_ff[i] + 8'h01;
							ovf_set[i] = (low_ff[i] == BYTE_FULL);
						end
					end
				endcase
			end
		end
		// split high byte uses timer 1 controls
		if (split0) begin
			ovf_set[1] = 1'b0;
			if (step_bus.tick && run_ff[1]) begin
				nxt_high[0] = high_ff[0] + 8'h01;
				ovf_set[1] = (high_ff[0] == BYTE_FULL);
			end
		end
		if (SFR_WR && SFR_ADDR == ADDR_LOW0) nxt_low[0] = SFR_WDATA;
		if (SFR_WR && SFR_ADDR == ADDR_LOW1) nxt_low[1] = SFR_WDATA;
		if (SFR_WR && SFR_ADDR == ADDR_HIGH0) nxt_high[0] = SFR_WDATA;
		if (SFR_WR && SFR_ADDR == ADDR_HIGH1) nxt_high[1] = SFR_WDATA;
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			low_ff <= '{COUNT_RESET, COUNT_RESET};
			high_ff <= '{COUNT_RESET, COUNT_RESET};
		end else begin
			low_ff <= nxt_low;
			high_ff <= nxt_high;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode register, whole byte writes only
	// byte access, zero reset
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= MODE_RESET;
		end else if (SFR_WR && SFR_ADDR == ADDR_MODE) begin
			mode_ff <= SFR_WDATA;
		end
	end

	// Control register byte and bit writes
	assign bit_hit = SFR_BIT_WR && (SFR_BIT_ADDR[7:3] == CTL_BIT_BASE);
	assign bit_idx = SFR_BIT_ADDR[2:0];

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			run_ff <= {CTL_RESET[CTL_RUN_BIT0 + CTL_PAIR], CTL_RESET[CTL_RUN_BIT0]};
			ext_ctl_ff <= CTL_RESET[3:0];
		end else if (SFR_WR && SFR_ADDR == ADDR_CTL) begin
			run_ff <= {SFR_WDATA[CTL_RUN_BIT0 + CTL_PAIR], SFR_WDATA[CTL_RUN_BIT0]};
			ext_ctl_ff <= SFR_WDATA[3:0];
		end else if (bit_hit) begin
			for (int i = 0; i < 2; i++) begin
				if (int'(bit_idx) == CTL_RUN_BIT0 + CTL_PAIR * i) run_ff[i] <= SFR_BIT_VAL;
			end
			if (bit_idx < 3'h4) ext_ctl_ff[bit_idx[1:0]] <= SFR_BIT_VAL;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= {CTL_RESET[CTL_FLAG_BIT0 + CTL_PAIR], CTL_RESET[CTL_FLAG_BIT0]};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (ovf_set[i]) begin
					flag_ff[i] <= 1'b1;
				end else if (i == 0 ? VEC_ACK_ZERO : VEC_ACK_ONE) begin
					flag_ff[i] <= 1'b0;
				end else if (SFR_WR && SFR_ADDR == ADDR_CTL) begin
					flag_ff[i] <= SFR_WDATA[CTL_FLAG_BIT0 + CTL_PAIR * i];
				end else if (bit_hit && int'(bit_idx) == CTL_FLAG_BIT0 + CTL_PAIR * i) begin
					flag_ff[i] <= SFR_BIT_VAL;
				end
			end
		end
	end
	assign OVERFLOW_FLAG_ZERO = flag_ff[0];
	assign OVERFLOW_FLAG_ONE = flag_ff[1];

	////////////////////////////////////////////////////////////////////////
	// Registered read data, one cycle after the address
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= READ_NONE;
		end else if (SFR_ADDR == ADDR_CTL) begin
			rdata_ff <= {flag_ff[1], run_ff[1], flag_ff[0], run_ff[0], ext_ctl_ff};
		end else if (SFR_ADDR == ADDR_MODE) begin
			rdata_ff <= mode_ff;
		end else if (SFR_ADDR == ADDR_LOW0) begin
			rdata_ff <= low_ff[0];
		end else if (SFR_ADDR == ADDR_LOW1) begin
			rdata_ff <= low_ff[1];
		end else if (SFR_ADDR == ADDR_HIGH0) begin
			rdata_ff <= high_ff[0];
		end else if (SFR_ADDR == ADDR_HIGH1) begin
			rdata_ff <= high_ff[1];
		end else begin
			rdata_ff <= READ_NONE;
		end
	end
	assign SFR_RDATA = rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_MODE_BYTE_ONLY: assert property (!(SFR_WR && SFR_ADDR == ADDR_MODE) |=> $stable(mode_ff)) else $error("mode register changed without byte write");
	AST_RUN_STOP: assert property ((!run_ff[0] && !split0 && !cnt_wr[0]) |=> $stable(low_ff[0]) && $stable(high_ff[0])) else $error("timer 0 counted while stopped");
	AST_GATE_LOW: assert property ((gate_sel[0] && !GATE_PIN_ZERO && !cnt_wr[0] && !split0) |=> $stable(low_ff[0])) else $error("timer 0 counted with gate pin low");
	AST_RELOAD: assert property ((md[0] == MODE_RELOAD8 && step_ok[0] && low_ff[0] == BYTE_FULL && !cnt_wr[0]) |=> low_ff[0] == $past(high_ff[0]) && $stable(high_ff[0]) && flag_ff[0]) else $error("auto reload wrong");
	AST_CASCADE_WRAP: assert property ((md[0] == MODE_CASCADE16 && step_ok[0] && low_ff[0] == BYTE_FULL && high_ff[0] == BYTE_FULL && !cnt_wr[0]) |=> flag_ff[0] && high_ff[0] == COUNT_RESET && low_ff[0] == COUNT_RESET) else $error("16-bit wrap did not flag");
	AST_PRESCALE_CARRY: assert property ((md[1] == MODE_PRESCALE13 && step_ok[1] && low_ff[1][4:0] != PRESCALE_FULL && !cnt_wr[1]) |=> $stable(high_ff[1])) else $error("high byte moved before prescaler carry");
	AST_TIMER1_STOPPED: assert property ((md[1] == MODE_SPLIT && !cnt_wr[1]) |=> $stable(low_ff[1]) && $stable(high_ff[1])) else $error("timer 1 counted in mode 11");
	AST_SPLIT_HIGH: assert property ((split0 && step_bus.tick && run_ff[1] && high_ff[0] == BYTE_FULL) |=> flag_ff[1]) else $error("split high byte overflow lost");
	AST_TIMER_RATE: assert property ((md[1] == MODE_CASCADE16 && !csel[1] && enable[1] && step_bus.tick && low_ff[1] != BYTE_FULL && !cnt_wr[1]) |=> low_ff[1] == $past(low_ff[1]) + 8'h01) else $error("timer 1 missed machine cycle");
endmodule : dual_timer_top

/* File: core/machine_phase.sv */
// Machine cycle sequencer and count pin edge sampler
module machine_phase
	import tmr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// External count pins
	input wire logic [1:0] count_pins,
	// Strobes to the counters
	timer_step_if.src step
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [3:0] phase_ff;
	logic [1:0] smp_ff;
	logic [1:0] pend_ff;

	////////////////////////////////////////////////////////////////////////
	// Phase counter, one pass per machine cycle
	// twelve clock cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_ff <= 4'h0;
		end else if (phase_ff == PHASE_LAST) begin
			phase_ff <= 4'h0;
		end else begin
			phase_ff <= phase_ff + 4'h1;
		end
	end

	// Update strobe once per machine cycle
	assign step.tick = (phase_ff == PHASE_UPDATE);

	AST_TICK_PERIOD: assert property (step.tick |-> ##1 (!step.tick)[*8] ##1 !step.tick ##1 !step.tick ##1 !step.tick ##1 step.tick) else $error("update strobe not every twelve clocks");

	////////////////////////////////////////////////////////////////////////
	// Per pin sampling and pending edge
	for (genvar i = 0; i < 2; i++) begin : g_pin
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				smp_ff[i] <= 1'b0;
			end else if (phase_ff == PHASE_SAMPLE) begin
				smp_ff[i] <= count_pins[i];
			end
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				pend_ff[i] <= 1'b0;
			end else if (phase_ff == PHASE_SAMPLE && smp_ff[i] && !count_pins[i]) begin
				pend_ff[i] <= 1'b1;
			end else if (phase_ff == PHASE_UPDATE) begin
				pend_ff[i] <= 1'b0;
			end
		end

		assign step.edge_evt[i] = pend_ff[i] && (phase_ff == PHASE_UPDATE);

		// edge only when high then low
		AST_EDGE_DETECT: assert property ((phase_ff == PHASE_SAMPLE && smp_ff[i] && !count_pins[i]) |-> ##7 step.edge_evt[i]) else $error("falling edge not counted at next update");
		// no edge without a falling sample
		AST_EDGE_CAUSE: assert property ($rose(pend_ff[i]) |-> $past(phase_ff) == PHASE_SAMPLE && !$past(count_pins[i])) else $error("edge pending without falling sample");
		AST_EVT_PHASE: assert property (step.edge_evt[i] |-> phase_ff == PHASE_UPDATE && $past(pend_ff[i])) else $error("edge event outside update phase");
	end
endmodule : machine_phase

/* File: inc/timer_step_if.sv */
// Count strobes from the machine cycle sequencer to the counters
interface timer_step_if;
	logic tick;
	logic [1:0] edge_evt;
	modport src (output tick, output edge_evt);
	modport dst (input tick, input edge_evt);
endinterface : timer_step_if

/* File: inc/tmr_pkg.sv */
// Constants and types shared by the dual timer/counter block
package tmr_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_CTL = 8'h88;
	localparam logic [7:0] ADDR_MODE = 8'h89;
	localparam logic [7:0] ADDR_LOW0 = 8'h8a;
	localparam logic [7:0] ADDR_LOW1 = 8'h8b;
	localparam logic [7:0] ADDR_HIGH0 = 8'h8c;
	localparam logic [7:0] ADDR_HIGH1 = 8'h8d;
	// Bit address range of the control register
	localparam logic [4:0] CTL_BIT_BASE = 5'h11;
	// Reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;
	// Mode register fields, timer 0 positions, timer 1 one nibble up
	localparam int MODE_GATE_BIT0 = 3;
	localparam int MODE_CSEL_BIT0 = 2;
	localparam int MODE_FIELD_LSB0 = 0;
	localparam int MODE_NIBBLE = 4;
	// Control register fields, timer 0 positions, timer 1 two bits up
	localparam int CTL_RUN_BIT0 = 4;
	localparam int CTL_FLAG_BIT0 = 5;
	localparam int CTL_PAIR = 2;
	// Counting constants
	localparam logic [4:0] PRESCALE_FULL = 5'h1f;
	localparam logic [7:0] BYTE_FULL = 8'hff;
	// Machine cycle timing in core clocks
	localparam int MC_CLKS = 12;
	localparam logic [3:0] PHASE_LAST = 4'(MC_CLKS - 1);
	localparam logic [3:0] PHASE_UPDATE = 4'h4;
	localparam logic [3:0] PHASE_SAMPLE = 4'h9;
	// Operating modes
	typedef enum logic [1:0] {MODE_PRESCALE13, MODE_CASCADE16, MODE_RELOAD8, MODE_SPLIT} timer_mode_t;
endpackage : tmr_pkg

/* File: tb/dual_timer_top_tb.sv */
// Self-checking testbench of the dual timer/counter block
module dual_timer_top_tb
	import tmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk;
	logic rst_n;
	logic [7:0] sfr_addr;
	logic sfr_wr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic bit_wr;
	logic [7:0] bit_addr;
	logic bit_val;
	logic [1:0] ack;
	logic [1:0] cpin;
	logic [1:0] gpin;
	logic [1:0] flag;
	logic [7:0] lo;
	logic [7:0] hi;
	logic [7:0] rv;
	int sh;
	int error_cnt;
	int samples_checked;

	dual_timer_top uut (.CLOCK(clk), .RST_N(rst_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata),
		.SFR_RDATA(sfr_rdata), .SFR_BIT_WR(bit_wr), .SFR_BIT_ADDR(bit_addr), .SFR_BIT_VAL(bit_val),
		.VEC_ACK_ZERO(ack[0]), .VEC_ACK_ONE(ack[1]), .COUNT_PIN_ZERO(cpin[0]), .COUNT_PIN_ONE(cpin[1]),
		.GATE_PIN_ZERO(gpin[0]), .GATE_PIN_ONE(gpin[1]), .OVERFLOW_FLAG_ZERO(flag[0]), .OVERFLOW_FLAG_ONE(flag[1]));
	pin_source src (.clk(clk), .count_pins(cpin), .gate_pins(gpin));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	//////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Byte write, one-cycle strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask : wr

	// Registered read, data one cycle behind address
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		sfr_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		rv = sfr_rdata;
	endtask : rd

	// Read and compare
	task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(what, rv, exp);
	endtask : expect_reg

	// Control bit write
	task automatic bwr(input logic [7:0] a, input logic v);
		@(posedge clk);
		bit_addr <= a;
		bit_val <= v;
		bit_wr <= 1'b1;
		@(posedge clk);
		bit_wr <= 1'b0;
	endtask : bwr

	// Run bit high for exactly n machine cycles
	task automatic run_ticks(input int t, input int n);
		bwr(8'(int'(ADDR_CTL) + CTL_RUN_BIT0 + CTL_PAIR * t), 1'b1);
		repeat (12 * n - 2) @(posedge clk);
		bwr(8'(int'(ADDR_CTL) + CTL_RUN_BIT0 + CTL_PAIR * t), 1'b0);
	endtask : run_ticks

	// Vector acknowledge pulse
	task automatic vec_ack(input int t);
		@(posedge clk);
		ack[t] <= 1'b1;
		@(posedge clk);
		ack[t] <= 1'b0;
		#1;
	endtask : vec_ack

	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	//////////////////////////////////////////////////
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		close_out();
	end

	// Test sequence
	initial begin
		rst_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_wdata = 8'h00;
		bit_wr = 1'b0;
		bit_addr = 8'h00;
		bit_val = 1'b0;
		ack = 2'h0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		expect_reg("mode", ADDR_MODE, 8'h00);
		expect_reg("unmapped", 8'h90, 8'h00);
		wr(ADDR_MODE, 8'ha5);
		// Bit address 0x89 lands in control bit 1, never in the mode register
		bwr(8'h89, 1'b1);
		expect_reg("mode", ADDR_MODE, 8'ha5);
		expect_reg("ctl", ADDR_CTL, 8'h02);
		$display("test reset done");
		for (int t = 0; t < 2; t++) begin
			sh = MODE_NIBBLE * t;
			lo = ADDR_LOW0 + 8'(t);
			hi = ADDR_HIGH0 + 8'(t);
			// Cascade: low wrap carries into high
			wr(ADDR_MODE, 8'(8'h01 << sh));
			wr(lo, 8'hff);
			wr(hi, 8'h12);
			run_ticks(t, 1);
			expect_reg("high", hi, 8'h13);
			expect_reg("low", lo, 8'h00);
			run_ticks(t, 5);
			expect_reg("low", lo, 8'h05);
			repeat (40) @(posedge clk);
			expect_reg("stopped", lo, 8'h05);
			// Full 16-bit wrap raises the flag
			wr(hi, 8'hff);
			wr(lo, 8'hff);
			run_ticks(t, 1);
			expect_reg("wrap high", hi, 8'h00);
			chk("wrap flag", {7'h0, flag[t]}, 8'h01);
			vec_ack(t);
			// Prescaled: high wraps and raises flag
			wr(ADDR_MODE, 8'h00);
			wr(lo, 8'h1f);
			wr(hi, 8'hff);
			run_ticks(t, 1);
			expect_reg("high", hi, 8'h00);
			// Upper three low bits take the prescaler carry, only the prescaler is checked
			rd(lo);
			chk("low5", rv & 8'h1f, 8'h00);
			chk("flag", {7'h0, flag[t]}, 8'h01);
			vec_ack(t);
			chk("flag", {7'h0, flag[t]}, 8'h00);
			// Thirty-two counts make exactly one carry
			run_ticks(t, 32);
			expect_reg("carry", hi, 8'h01);
			// Reload from high on low overflow
			wr(ADDR_MODE, 8'(8'h02 << sh));
			wr(hi, 8'hf0);
			wr(lo, 8'hfe);
			run_ticks(t, 2);
			expect_reg("low", lo, 8'hf0);
			expect_reg("high", hi, 8'hf0);
			chk("flag", {7'h0, flag[t]}, 8'h01);
			vec_ack(t);
			// Gate pin low holds, high lets it run
			wr(ADDR_MODE, 8'(8'h09 << sh));
			wr(lo, 8'h00);
			run_ticks(t, 3);
			expect_reg("gated", lo, 8'h00);
			src.set_gate(t, 1'b1);
			run_ticks(t, 3);
			expect_reg("open", lo, 8'h03);
			src.set_gate(t, 1'b0);
			// Counter function counts pin falls only
			wr(ADDR_MODE, 8'(8'h05 << sh));
			wr(lo, 8'h00);
			bwr(8'(int'(ADDR_CTL) + CTL_RUN_BIT0 + CTL_PAIR * t), 1'b1);
			src.falls(t, 3);
			repeat (30) @(posedge clk);
			expect_reg("falls", lo, 8'h03);
			bwr(8'(int'(ADDR_CTL) + CTL_RUN_BIT0 + CTL_PAIR * t), 1'b0);
			$display("test timer %0d done", t);
		end
		// Mode 3 holds timer 1
		wr(ADDR_MODE, 8'h30);
		wr(ADDR_LOW1, 8'h05);
		run_ticks(1, 2);
		expect_reg("held", ADDR_LOW1, 8'h05);
		// Split timer 0: high byte on run bit one and flag one
		wr(ADDR_MODE, 8'h03);
		wr(ADDR_HIGH0, 8'hff);
		wr(ADDR_LOW0, 8'h00);
		run_ticks(1, 1);
		expect_reg("split high", ADDR_HIGH0, 8'h00);
		expect_reg("split low", ADDR_LOW0, 8'h00);
		chk("flag one", {7'h0, flag[1]}, 8'h01);
		chk("flag zero", {7'h0, flag[0]}, 8'h00);
		run_ticks(0, 2);
		expect_reg("split low", ADDR_LOW0, 8'h02);
		expect_reg("split high", ADDR_HIGH0, 8'h00);
		$display("test split done");
		close_out();
	end
endmodule : dual_timer_top_tb

/* File: tb/pin_source.sv */
// Far side model: external count pins and gate pins
module pin_source (
	// Clock
	input wire logic clk,
	// Pins toward the timers
	output logic [1:0] count_pins,
	output logic [1:0] gate_pins
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins idle low
	initial begin
		count_pins = 2'h0;
		gate_pins = 2'h0;
	end

	// Drive one gate pin level
	task automatic set_gate(input int idx, input logic val);
		@(posedge clk);
		gate_pins[idx] <= val;
	endtask : set_gate

	// each level held beyond a machine cycle
	task automatic falls(input int idx, input int n);
		repeat (n) begin
			@(posedge clk);
			count_pins[idx] <= 1'b1;
			repeat (14) @(posedge clk);
			count_pins[idx] <= 1'b0;
			repeat (14) @(posedge clk);
		end
	endtask : falls
endmodule : pin_source
